// *** hdl/fts_cfg.svh ***
// register map, field positions, reset values and summary of the frame timer sync logic
// Summary of operation
// RULE1 - line sync input reaches outputs four clocks later
// RULE2 - pixel counter loads preset third clock after edge
// RULE3 - software sets line preset 4 for exact alignment
// RULE4 - limit match clears counter, sync out aligns
// RULE5 - software clears follow enable for precise alignment
// RULE6 - row preset offsets internal video by scanlines
// RULE7 - odd row preset inverts field parity when interlaced
// RULE8 - high impedance pin neither drives nor is recognised
// RULE9 - field lock needs one received horizontal pulse
// RULE10 - software makes pins inputs, then high impedance
// RULE11 - lock bit makes timer 1 slave of timer 0
// RULE12 - timer 1 reloads one clock after timer 0
// RULE13 - software sets timer 1 line preset to 1
// RULE14 - locked timer 1 follows timer 0 as source
// RULE15 - follow enable picks external edges or counters
// RULE16 - line or composite falling edge reloads pixel counter
// RULE17 - pixel counter clears when equal to limit
// RULE18 - inputs synchronised then falling edge detected
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH
`define FTS_REG_CTRL 3'h0
`define FTS_REG_LIMITS 3'h1
`define FTS_REG_PRESETS 3'h2
`define FTS_REG_WIDTHS 3'h3
`define FTS_REG_STATUS 3'h4
`define FTS_TIMER_SEL 5
`define FTS_HI_LSB 16
`define FTS_CTRL_LMODE 0
`define FTS_CTRL_FMODE 2
`define FTS_CTRL_CMODE 4
`define FTS_CTRL_FOLLOW 6
`define FTS_CTRL_ILACE 7
`define FTS_CTRL_LOCK 8
`define FTS_STAT_FIELD 31
`define FTS_CTRL_RST 32'h0000_0000
`define FTS_LIMITS_RST 32'h020c_0359
`define FTS_PRESETS_RST 32'h0000_0004
`define FTS_WIDTHS_RST 32'h0003_003f
`define FTS_SYNC_IDLE 3'h7
`endif

// *** hdl/fts_pkg.sv ***
// shared types of the frame timer sync logic
package fts_pkg;
	typedef enum logic [1:0] {
		FTS_PIN_HIZ,
		FTS_PIN_IN,
		FTS_PIN_OUT,
		FTS_PIN_SPARE
	} fts_pin_mode_t;
endpackage

// *** hdl/fts_top.sv ***
// two frame timers with external sync, skew presets, high impedance pins, frame lock and apb registers
`timescale 1ns/1ps
`include "fts_cfg.svh"

module fts_timer #(
	parameter int CW = 12
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [1:0] line_mode_in,
	input wire logic [1:0] field_mode_in,
	input wire logic [1:0] comp_mode_in,
	input wire logic sync_follow_enable_in,
	input wire logic ilace_in,
	input wire logic use_ext_in,
	input wire logic ext_line_load_in,
	input wire logic ext_field_load_in,
	input wire logic [CW-1:0] line_length_limit_in,
	input wire logic [CW-1:0] row_limit_in,
	input wire logic [CW-1:0] line_counter_preset_in,
	input wire logic [CW-1:0] row_counter_preset_in,
	input wire logic [CW-1:0] line_width_in,
	input wire logic [CW-1:0] field_width_in,
	input wire logic line_sync_in,
	input wire logic field_sync_in,
	input wire logic composite_sync_pin_in,
	output logic line_sync_out,
	output logic line_sync_oe_n_out,
	output logic field_sync_out,
	output logic field_sync_oe_n_out,
	output logic composite_sync_pin_out,
	output logic composite_sync_pin_oe_n_out,
	output logic line_load_out,
	output logic field_load_out,
	output logic [CW-1:0] pixel_position_counter,
	output logic [CW-1:0] line_position_counter,
	output logic field_out
);
	function automatic logic is_mode(input logic [1:0] m, input fts_pkg::fts_pin_mode_t want);
		is_mode = (m == want);
	endfunction

	logic [2:0] sync_s1;
	logic [2:0] sync_s2;
	logic [2:0] sync_s3;
	logic [2:0] sync_held;
	logic [2:0] sync_fall;
	logic line_rec;
	logic field_rec;
	logic comp_rec;
	logic line_load;
	logic field_load;
	logic line_wrap;
	logic line_adv;
	logic field_wrap;
	logic line_start;
	logic field_start;
	logic [CW-1:0] line_pulse_cnt;
	logic [CW-1:0] field_pulse_cnt;
	logic line_act;
	logic field_act;
	logic line_seen;
	logic ext_field;

	// three-stage synchroniser, idle high since sync is active low
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync_s1 <= `FTS_SYNC_IDLE;
			sync_s2 <= `FTS_SYNC_IDLE;
			sync_s3 <= `FTS_SYNC_IDLE;
		end else begin
			sync_s1 <= {composite_sync_pin_in, field_sync_in, line_sync_in}; // RULE18
			sync_s2 <= sync_s1;
			sync_s3 <= sync_s2;
		end
	end

	// a level only counts once stages two and three agree
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync_held <= `FTS_SYNC_IDLE;
		end else begin
			sync_held <= ((sync_s2 ~^ sync_s3) & sync_s2) | ((sync_s2 ^ sync_s3) & sync_held); // RULE18
		end
	end

	assign sync_fall = sync_held & ~sync_s2 & ~sync_s3; // RULE18
	assign line_rec = is_mode(line_mode_in, fts_pkg::FTS_PIN_IN); // RULE8
	assign field_rec = is_mode(field_mode_in, fts_pkg::FTS_PIN_IN); // RULE8
	assign comp_rec = is_mode(comp_mode_in, fts_pkg::FTS_PIN_IN); // RULE8

	// locked timer ignores its own pins and follows the master's reloads
	assign line_load = use_ext_in ? ext_line_load_in
		: ((sync_fall[0] & line_rec) | (sync_fall[2] & comp_rec)); // RULE16 RULE14
	assign field_load = use_ext_in ? ext_field_load_in : (sync_fall[1] & field_rec); // RULE14
	assign line_load_out = line_load;
	assign field_load_out = field_load;

	assign line_wrap = (pixel_position_counter == line_length_limit_in); // RULE17
	assign line_adv = line_wrap | line_load;
	assign field_wrap = line_adv & (line_position_counter == row_limit_in);
	assign line_start = sync_follow_enable_in ? line_load : line_wrap; // RULE15
	assign field_start = sync_follow_enable_in ? field_load : field_wrap; // RULE15

	// load beats the limit clear so a preset of 4 lands cleanly
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pixel_position_counter <= '0;
		end else if (line_load) begin
			pixel_position_counter <= line_counter_preset_in; // RULE2 RULE1
		end else if (line_wrap) begin
			pixel_position_counter <= '0; // RULE17 RULE4
		end else begin
			pixel_position_counter <= pixel_position_counter + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			line_position_counter <= '0;
		end else if (field_load) begin
			line_position_counter <= row_counter_preset_in; // RULE6
		end else if (field_wrap) begin
			line_position_counter <= '0;
		end else if (line_adv) begin
			line_position_counter <= line_position_counter + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			line_pulse_cnt <= '0;
		end else if (line_start) begin
			line_pulse_cnt <= line_width_in; // RULE4
		end else if (line_act) begin
			line_pulse_cnt <= line_pulse_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			field_pulse_cnt <= '0;
		end else if (field_start) begin
			field_pulse_cnt <= field_width_in;
		end else if (field_act && line_adv) begin
			field_pulse_cnt <= field_pulse_cnt - 1'b1;
		end
	end

	assign line_act = |line_pulse_cnt;
	assign field_act = |field_pulse_cnt;

	// parity from a vertical edge is trusted only after a horizontal pulse
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			line_seen <= 1'b0;
		end else if (line_load) begin
			line_seen <= 1'b1; // RULE9
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ext_field <= 1'b0;
		end else if (field_load ? line_seen : (field_wrap & ilace_in)) begin
			ext_field <= ~ext_field; // RULE9
		end
	end

	assign field_out = ext_field ^ (ilace_in & row_counter_preset_in[0]); // RULE7

	// high impedance and input modes release the pin
	assign line_sync_out = ~line_act;
	assign field_sync_out = ~field_act;
	assign composite_sync_pin_out = ~(line_act | field_act);
	assign line_sync_oe_n_out = ~is_mode(line_mode_in, fts_pkg::FTS_PIN_OUT); // RULE8
	assign field_sync_oe_n_out = ~is_mode(field_mode_in, fts_pkg::FTS_PIN_OUT); // RULE8
	assign composite_sync_pin_oe_n_out = ~is_mode(comp_mode_in, fts_pkg::FTS_PIN_OUT); // RULE8

	property p_pin_latency;
		@(posedge clk_in) disable iff (!rstn_in)
		(line_sync_in && line_rec && !comp_rec && !use_ext_in)[*3]
		##1 (!line_sync_in && line_rec && !comp_rec && !use_ext_in)[*3]
		|-> ##2 pixel_position_counter == $past(line_counter_preset_in);
	endproperty
	a_pin_latency: assert property (p_pin_latency) else $error("pixel counter not loaded three clocks after edge"); // RULE2

	property p_limit_clear;
		@(posedge clk_in) disable iff (!rstn_in)
		(line_wrap && !line_load) |=> (pixel_position_counter == '0);
	endproperty
	a_limit_clear: assert property (p_limit_clear) else $error("pixel counter missed clear at limit"); // RULE17

	property p_hiz_ignored;
		@(posedge clk_in) disable iff (!rstn_in)
		(!line_rec && !comp_rec && !use_ext_in) |-> !line_load;
	endproperty
	a_hiz_ignored: assert property (p_hiz_ignored) else $error("edge recognised on non-input pin"); // RULE8

	property p_no_drive;
		@(posedge clk_in) disable iff (!rstn_in)
		!is_mode(line_mode_in, fts_pkg::FTS_PIN_OUT) |-> line_sync_oe_n_out;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("line sync pin driven while not an output"); // RULE8

	property p_start_source;
		@(posedge clk_in) disable iff (!rstn_in)
		$rose(line_act) |-> $past(line_start) && ($past(sync_follow_enable_in) ? $past(line_load) : $past(line_wrap));
	endproperty
	a_start_source: assert property (p_start_source) else $error("line sync started by wrong source"); // RULE15

	property p_aligned_out;
		@(posedge clk_in) disable iff (!rstn_in)
		(!sync_follow_enable_in && line_wrap && line_width_in != '0) |=> !line_sync_out
			&& (pixel_position_counter == ($past(line_load) ? $past(line_counter_preset_in) : '0));
	endproperty
	a_aligned_out: assert property (p_aligned_out) else $error("sync output not low with counter clear"); // RULE4

	property p_row_preset;
		@(posedge clk_in) disable iff (!rstn_in)
		field_load |=> line_position_counter == $past(row_counter_preset_in);
	endproperty
	a_row_preset: assert property (p_row_preset) else $error("line counter not loaded from row preset"); // RULE6

	property p_field_needs_line;
		@(posedge clk_in) disable iff (!rstn_in)
		(field_load && !line_seen) |=> $stable(ext_field);
	endproperty
	a_field_needs_line: assert property (p_field_needs_line) else $error("field parity taken without line pulse"); // RULE9

	property p_parity;
		@(posedge clk_in) disable iff (!rstn_in)
		(ilace_in && $changed(row_counter_preset_in[0]) && !$past(field_load) && !$past(field_wrap)) |-> $changed(field_out);
	endproperty
	a_parity: assert property (p_parity) else $error("odd row preset did not flip parity"); // RULE7

	c_pin_load: cover property (@(posedge clk_in) disable iff (!rstn_in) line_load && !use_ext_in);
	c_follow_start: cover property (@(posedge clk_in) disable iff (!rstn_in) sync_follow_enable_in && line_start);
	c_field_load: cover property (@(posedge clk_in) disable iff (!rstn_in) field_load && line_seen);
endmodule // fts_timer

module fts_top #(
	parameter int CW = 12
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [1:0] line_sync_in,
	input wire logic [1:0] field_sync_in,
	input wire logic [1:0] composite_sync_pin_in,
	output logic [1:0] line_sync_out,
	output logic [1:0] line_sync_oe_n_out,
	output logic [1:0] field_sync_out,
	output logic [1:0] field_sync_oe_n_out,
	output logic [1:0] composite_sync_pin_out,
	output logic [1:0] composite_sync_pin_oe_n_out
);
	logic [31:0] control_word [2];
	logic [31:0] limits [2];
	logic [31:0] presets [2];
	logic [31:0] widths [2];
	logic [CW-1:0] pix [2];
	logic [CW-1:0] row [2];
	logic [1:0] field;
	logic [1:0] line_load;
	logic [1:0] field_load;
	logic lock_line_load;
	logic lock_field_load;
	logic timer_lock_enable;
	logic sel_t;
	logic [2:0] sel_r;
	logic addr_ok;
	logic wr_ok;
	logic [31:0] rd_word;

	function automatic logic decode_ok(input logic [7:0] a, input logic wr);
		decode_ok = (a[7:6] == 2'h0) && (a[1:0] == 2'h0) && (a[4:2] <= `FTS_REG_STATUS)
			&& !(wr && a[4:2] == `FTS_REG_STATUS);
	endfunction

	assign sel_t = paddr_in[`FTS_TIMER_SEL];
	assign sel_r = paddr_in[4:2];
	assign addr_ok = decode_ok(paddr_in, pwrite_in);
	assign wr_ok = psel_in && penable_in && pwrite_in && addr_ok;
	assign pready_out = 1'b1;
	assign timer_lock_enable = control_word[1][`FTS_CTRL_LOCK];

	// lock bit only exists in timer 1's control word
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			control_word[0] <= `FTS_CTRL_RST;
			control_word[1] <= `FTS_CTRL_RST;
			limits[0] <= `FTS_LIMITS_RST;
			limits[1] <= `FTS_LIMITS_RST;
			presets[0] <= `FTS_PRESETS_RST;
			presets[1] <= `FTS_PRESETS_RST;
			widths[0] <= `FTS_WIDTHS_RST;
			widths[1] <= `FTS_WIDTHS_RST;
		end else if (wr_ok) begin
			case (sel_r)
				`FTS_REG_CTRL: begin
					control_word[sel_t] <= pwdata_in & (sel_t ? 32'h0000_01ff : 32'h0000_00ff); // RULE11
				end
				`FTS_REG_LIMITS: begin
					limits[sel_t] <= pwdata_in;
				end
				`FTS_REG_PRESETS: begin
					presets[sel_t] <= pwdata_in;
				end
				`FTS_REG_WIDTHS: begin
					widths[sel_t] <= pwdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rd_word = 32'h0;
		case (sel_r)
			`FTS_REG_CTRL: rd_word = control_word[sel_t];
			`FTS_REG_LIMITS: rd_word = limits[sel_t];
			`FTS_REG_PRESETS: rd_word = presets[sel_t];
			`FTS_REG_WIDTHS: rd_word = widths[sel_t];
			`FTS_REG_STATUS: begin
				rd_word[CW-1:0] = pix[sel_t];
				rd_word[`FTS_HI_LSB +: CW] = row[sel_t];
				rd_word[`FTS_STAT_FIELD] = field[sel_t];
			end
			default: rd_word = 32'h0;
		endcase
	end

	// read data captured in setup so the access phase needs no wait
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prdata_out <= 32'h0;
			pslverr_out <= 1'b0;
		end else if (psel_in && !penable_in) begin
			prdata_out <= (addr_ok && !pwrite_in) ? rd_word : 32'h0;
			pslverr_out <= !addr_ok;
		end
	end

	// master reloads reach the slave one clock later
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lock_line_load <= 1'b0;
			lock_field_load <= 1'b0;
		end else begin
			lock_line_load <= line_load[0]; // RULE12
			lock_field_load <= field_load[0]; // RULE12
		end
	end

	// both timers share clk_in, so lock needs no clock switch
	for (genvar i = 0; i < 2; i++) begin : g_tmr
		fts_timer #(.CW(CW)) u_tmr (
			.clk_in(clk_in),
			.rstn_in(rstn_in),
			.line_mode_in(control_word[i][`FTS_CTRL_LMODE +: 2]),
			.field_mode_in(control_word[i][`FTS_CTRL_FMODE +: 2]),
			.comp_mode_in(control_word[i][`FTS_CTRL_CMODE +: 2]),
			.sync_follow_enable_in(control_word[i][`FTS_CTRL_FOLLOW]),
			.ilace_in(control_word[i][`FTS_CTRL_ILACE]),
			.use_ext_in((i == 1) && timer_lock_enable), // RULE11 RULE14
			.ext_line_load_in(lock_line_load),
			.ext_field_load_in(lock_field_load),
			.line_length_limit_in(limits[i][CW-1:0]),
			.row_limit_in(limits[i][`FTS_HI_LSB +: CW]),
			.line_counter_preset_in(presets[i][CW-1:0]),
			.row_counter_preset_in(presets[i][`FTS_HI_LSB +: CW]),
			.line_width_in(widths[i][CW-1:0]),
			.field_width_in(widths[i][`FTS_HI_LSB +: CW]),
			.line_sync_in(line_sync_in[i]),
			.field_sync_in(field_sync_in[i]),
			.composite_sync_pin_in(composite_sync_pin_in[i]),
			.line_sync_out(line_sync_out[i]),
			.line_sync_oe_n_out(line_sync_oe_n_out[i]),
			.field_sync_out(field_sync_out[i]),
			.field_sync_oe_n_out(field_sync_oe_n_out[i]),
			.composite_sync_pin_out(composite_sync_pin_out[i]),
			.composite_sync_pin_oe_n_out(composite_sync_pin_oe_n_out[i]),
			.line_load_out(line_load[i]),
			.field_load_out(field_load[i]),
			.pixel_position_counter(pix[i]),
			.line_position_counter(row[i]),
			.field_out(field[i])
		);
	end

	property p_lock_follow;
		@(posedge clk_in) disable iff (!rstn_in)
		(timer_lock_enable && line_load[0]) ##1 timer_lock_enable |-> line_load[1] && !$past(line_load[1]);
	endproperty
	a_lock_follow: assert property (p_lock_follow) else $error("slave timer did not reload one clock after master"); // RULE12

	property p_lock_pins;
		@(posedge clk_in) disable iff (!rstn_in)
		(timer_lock_enable && !lock_line_load) |-> !line_load[1];
	endproperty
	a_lock_pins: assert property (p_lock_pins) else $error("locked slave followed its own pin"); // RULE14

	c_lock: cover property (@(posedge clk_in) disable iff (!rstn_in) timer_lock_enable && line_load[1]);
endmodule // fts_top

// *** dv/fts_sync_src.sv ***
// external video source model driving the active-low sync pins of both timers
`timescale 1ns/1ps
module fts_sync_src (
	input wire logic clk_in,
	output logic [1:0] line_sync_out,
	output logic [1:0] field_sync_out,
	output logic [1:0] composite_sync_pin_out
);
	logic [5:0] low_q;
	int hold;
	initial begin
		low_q = 6'h00;
		hold = 0;
	end
	// only touches low_q when a pulse ends, so a new request never races the release
	always @(posedge clk_in) begin
		if (hold == 1)
			low_q <= 6'h00;
		if (hold > 0)
			hold <= hold - 1;
	end
	// pin 0 line, 1 field, 2 composite; low four clocks, above the two-sample need
	task automatic drop(input int t, input int pin);
		low_q[pin * 2 + t] <= 1'b1;
		hold <= 4;
	endtask
	assign line_sync_out = ~low_q[1:0];
	assign field_sync_out = ~low_q[3:2];
	assign composite_sync_pin_out = ~low_q[5:4];
endmodule // fts_sync_src

// *** dv/fts_top_tb.sv ***
// self-checking bench for the frame timer sync logic
`timescale 1ns/1ps
`include "fts_cfg.svh"
module fts_top_tb;
	logic clk_in, rstn_in, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_out;
	logic pready_out, pslverr_out;
	logic [1:0] l_in, f_in, c_in, line_sync_out, l_oe, field_sync_out, f_oe, composite_sync_pin_out, c_oe;
	int error_cnt = 0;
	int num_checks = 0;
	fts_top #(.CW(12)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .line_sync_in(l_in), .field_sync_in(f_in),
		.composite_sync_pin_in(c_in), .line_sync_out(line_sync_out), .line_sync_oe_n_out(l_oe),
		.field_sync_out(field_sync_out), .field_sync_oe_n_out(f_oe),
		.composite_sync_pin_out(composite_sync_pin_out), .composite_sync_pin_oe_n_out(c_oe));
	fts_sync_src src_u (.clk_in(clk_in), .line_sync_out(l_in), .field_sync_out(f_in), .composite_sync_pin_out(c_in));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic tally_and_finish;
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic chk_n(input int g, input int e, input string m);
		num_checks++;
		if (g != e) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %0d want %0d", $time, m, g, e);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready_out !== 1'b1 && k < 50);
		if (k >= 50) begin
			error_cnt++;
			$display("unexpected at %0t: no bus answer", $time);
			tally_and_finish();
		end
		r = prdata_out;
		e = pslverr_out;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [7:0] ra(input int t, input logic [2:0] i);
		return 8'((t << `FTS_TIMER_SEL) | (32'(i) << 2));
	endfunction
	function automatic logic [31:0] cw(input fts_pkg::fts_pin_mode_t l, input fts_pkg::fts_pin_mode_t f,
		input fts_pkg::fts_pin_mode_t c, input logic fo, input logic il, input logic lk);
		return {23'h0, lk, il, fo, c, f, l};
	endfunction
	task automatic wr(input int t, input logic [2:0] i, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(ra(t, i), 1'b1, d, r, e);
	endtask
	task automatic rd(input int t, input logic [2:0] i, output logic [31:0] r);
		logic e;
		apb(ra(t, i), 1'b0, 32'h0, r, e);
	endtask
	task automatic do_reset;
		rstn_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
	endtask
	// fall edge index counted from the edge after the sync drop; 0 when none
	task automatic meas(input int t, input int pin, input int obs, input int lo, input int win,
		output int f0, output int f1);
		logic [1:0] pv, cv;
		f0 = 0;
		f1 = 0;
		@(posedge clk_in);
		src_u.drop(t, pin);
		pv = obs ? composite_sync_pin_out : line_sync_out;
		for (int n = 1; n <= win; n++) begin
			@(negedge clk_in);
			cv = obs ? composite_sync_pin_out : line_sync_out;
			if (n >= lo && f0 == 0 && pv[0] && !cv[0])
				f0 = n;
			if (n >= lo && f1 == 0 && pv[1] && !cv[1])
				f1 = n;
			pv = cv;
		end
	endtask
	task automatic s_regs;
		logic [31:0] r;
		logic e;
		chk_w({26'h0, l_oe, f_oe, c_oe}, 32'h3f, "pins not released after reset");
		chk_w({26'h0, line_sync_out, field_sync_out, composite_sync_pin_out}, 32'h3f, "sync outputs not idle");
		for (int t = 0; t < 2; t++) begin
			rd(t, `FTS_REG_CTRL, r);
			chk_w(r, `FTS_CTRL_RST, "ctrl reset");
			rd(t, `FTS_REG_LIMITS, r);
			chk_w(r, `FTS_LIMITS_RST, "limits reset");
			rd(t, `FTS_REG_PRESETS, r);
			chk_w(r, `FTS_PRESETS_RST, "presets reset");
			rd(t, `FTS_REG_WIDTHS, r);
			chk_w(r, `FTS_WIDTHS_RST, "widths reset");
		end
		apb(8'h40, 1'b0, 32'h0, r, e);
		chk_w({31'h0, e}, 32'h1, "unmapped read not refused");
		apb(ra(0, `FTS_REG_STATUS), 1'b1, 32'hffff_ffff, r, e);
		chk_w({31'h0, e}, 32'h1, "status write not refused");
		wr(0, `FTS_REG_CTRL, 32'h0000_0100);
		rd(0, `FTS_REG_CTRL, r);
		chk_w(r, 32'h0, "lock bit kept on timer 0");
	endtask
	// pin 0: line in, composite out; pin 2: composite in, line out
	task automatic s_align(input int pin, input int p, input int l);
		int f0, f1;
		do_reset();
		if (pin == 0)
			wr(0, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_IN, fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_OUT, 0, 0, 0));
		else
			wr(0, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_OUT, fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_IN, 0, 0, 0));
		wr(0, `FTS_REG_LIMITS, 32'(l));
		wr(0, `FTS_REG_PRESETS, 32'(p));
		wr(0, `FTS_REG_WIDTHS, 32'h1);
		chk_w({30'h0, l_oe[0], c_oe[0]}, (pin == 0) ? 32'h2 : 32'h1, "pin enables");
		meas(0, pin, (pin == 0) ? 1 : 0, 6, l + 20, f0, f1);
		// a line is l + 1 clocks; a fall launched at an edge shows at the negedge after it
		chk_n(f0, 6 + l - p, "sync out fall edge");
	endtask
	task automatic s_follow;
		int f0, f1;
		do_reset();
		wr(0, `FTS_REG_LIMITS, 32'h0fff_0fff);
		wr(0, `FTS_REG_WIDTHS, 32'h1);
		wr(0, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_IN, fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_OUT, 1, 0, 0));
		meas(0, 0, 1, 1, 12, f0, f1);
		chk_n((f0 == 4 || f0 == 5) ? 1 : 0, 1, "follow pulse latency");
		wr(0, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_IN, fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_OUT, 0, 0, 0));
		meas(0, 0, 1, 1, 12, f0, f1);
		chk_n(f0, 0, "pulse without follow");
		wr(0, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_OUT, 1, 0, 0));
		meas(0, 0, 1, 1, 12, f0, f1);
		chk_n(f0, 0, "edge seen on released pin");
	endtask
	task automatic s_lock(input int l);
		int f0, f1;
		do_reset();
		wr(0, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_IN, fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_OUT, 0, 0, 0));
		wr(0, `FTS_REG_LIMITS, 32'(l));
		wr(0, `FTS_REG_WIDTHS, 32'h1);
		wr(1, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_OUT, 0, 0, 1));
		wr(1, `FTS_REG_LIMITS, 32'(l));
		wr(1, `FTS_REG_PRESETS, 32'h1);
		wr(1, `FTS_REG_WIDTHS, 32'h1);
		// slave may still wrap on its own before its first forwarded load, so skip that edge
		meas(0, 0, 1, 7, l + 20, f0, f1);
		chk_n(f0, 2 + l, "master fall edge");
		chk_n(f1, 6 + l, "slave fall edge");
	endtask
	task automatic s_rows;
		logic [31:0] r;
		int f0, f1;
		do_reset();
		wr(0, `FTS_REG_LIMITS, 32'h0fff_0fff);
		wr(0, `FTS_REG_PRESETS, 32'h0005_0004);
		wr(0, `FTS_REG_CTRL, cw(fts_pkg::FTS_PIN_HIZ, fts_pkg::FTS_PIN_IN, fts_pkg::FTS_PIN_HIZ, 0, 1, 0));
		rd(0, `FTS_REG_STATUS, r);
		chk_w({31'h0, r[`FTS_STAT_FIELD]}, 32'h1, "odd preset parity");
		meas(0, 1, 1, 1, 10, f0, f1);
		rd(0, `FTS_REG_STATUS, r);
		chk_w({20'h0, r[`FTS_HI_LSB +: 12]}, 32'h5, "row offset after field edge");
		wr(0, `FTS_REG_PRESETS, 32'h0004_0004);
		rd(0, `FTS_REG_STATUS, r);
		chk_w({31'h0, r[`FTS_STAT_FIELD]}, 32'h0, "even preset parity");
	endtask
	initial begin
		rstn_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		do_reset();
		s_regs();
		s_align(0, 4, 64);
		s_align(0, 6, 64);
		s_align(2, 4, 64);
		s_follow();
		s_lock(64);
		s_rows();
		tally_and_finish();
	end
endmodule // fts_top_tb
